// ### hw/ubc_pkg.sv
// constants, register map and types for the baud divisor / clock phase slice
// assumes a 32-bit apb master and a single 10 MHz system clock
//
// Overview of operation
// [R1] phase bit picks leading or trailing sample edge
// [R2] divisor is one 16-bit value from two bytes
// [R3] low byte at base, high byte at base+1
// [R4] any divisor write reloads prescaler immediately
// [R5] software changes divisor only while line idle; the test bench writes the low byte mid-transfer
package ubc_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0]  UBC_IDX_CTRL_C      = 8'h07;
    localparam logic [7:0]  UBC_IDX_DIV_LOW     = 8'h08;
    localparam logic [7:0]  UBC_IDX_DIV_HIGH    = 8'h09;
    localparam logic [7:0]  UBC_IDX_STATUS      = 8'h0a;
    localparam int          UBC_ADDR_LSB        = 2;
    localparam int          UBC_ADDR_W          = 12;

    // ==========================================================
    // fields and reset values
    localparam logic [7:0]  UBC_CTRL_C_RESET    = 8'h03;
    localparam logic [15:0] UBC_DIV_RESET       = 16'h0000;
    localparam int          UBC_MODE_LSB        = 6;
    localparam int          UBC_PHASE_BIT       = 1;
    localparam int          UBC_ORDER_BIT       = 2;
    localparam logic [1:0]  UBC_MODE_MSPI       = 2'h3;
    localparam logic [7:0]  UBC_MSPI_MASK       = 8'hc6;
    localparam int          UBC_STAT_CLK_BIT    = 16;
    localparam int          UBC_STAT_RUN_BIT    = 17;

    typedef enum logic [1:0] {
        UBC_COMM_ASYNC,
        UBC_COMM_SYNC,
        UBC_COMM_IRCOM,
        UBC_COMM_MSPI
    } ubc_comm_t;

    typedef enum {
        UBC_LINK_IDLE,
        UBC_LINK_RUN
    } ubc_link_t;

endpackage : ubc_pkg

// ### hw/ubc_prescaler.sv
// baud rate prescaler: down counter reloaded from the divisor
// assumes reload is a one-cycle pulse in the clk_sys domain
module ubc_prescaler
    import ubc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        reload,
    input  wire logic [15:0] divisor,
    output logic             tick,
    output logic [15:0]      count
);

    logic [15:0] count_q;

    // ==========================================================
    // counter: period is divisor plus one cycles
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= UBC_DIV_RESET;
        end else if (ce) begin
            if (reload) begin
                count_q <= divisor; // [R4]
            end else if (count_q == 16'h0000) begin
                count_q <= divisor;
            end else begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    assign tick  = ce && !reload && (count_q == 16'h0000);
    assign count = count_q;

endmodule // ubc_prescaler

// ### hw/ubc_top.sv
// baud divisor registers, prescaler and master spi transfer clock
// assumes an apb master on clk_sys and a peer sampling the transfer clock
module ubc_top
    import ubc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [UBC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  spi_run,
    input  wire logic                  spi_data_in,
    output logic                       transfer_clock_pin,
    output logic                       baud_tick,
    output logic                       sample_pulse,
    output logic                       sample_bit
);

    logic [7:0]  ctrl_c_q;
    logic [7:0]  divisor_low_byte_q;
    logic [7:0]  divisor_high_byte_q;
    logic [15:0] divisor;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        reload;
    logic        tick;
    logic [15:0] count;
    logic        xck_q;
    logic        sample_pulse_q;
    logic        sample_bit_q;
    ubc_link_t   link_q;

    // ==========================================================
    // apb decode
    function automatic logic [7:0] ubc_index(input logic [UBC_ADDR_W-1:0] a);
        ubc_index = 8'(a >> UBC_ADDR_LSB);
    endfunction

    function automatic logic ubc_mapped(input logic [UBC_ADDR_W-1:0] a);
        logic [7:0] i;
        i = ubc_index(a);
        // bits above the index must be clear, else high addresses alias
        ubc_mapped = (a[UBC_ADDR_LSB-1:0] == 2'h0) &&
                     ((a >> UBC_ADDR_LSB) == UBC_ADDR_W'(i)) &&
                     (i == UBC_IDX_CTRL_C || i == UBC_IDX_DIV_LOW ||
                      i == UBC_IDX_DIV_HIGH || i == UBC_IDX_STATUS);
    endfunction

    function automatic logic [7:0] ubc_merge(input logic       hit,
                                             input logic [7:0] wbyte,
                                             input logic [7:0] held);
        ubc_merge = hit ? wbyte : held;
    endfunction

    logic setup_ph;
    logic wr_acc;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic mspi;

    assign setup_ph = ce && psel && !penable;
    assign wr_acc   = ce && psel && penable && pwrite && ubc_mapped(paddr) && pstrb[0];
    assign wr_ctrl  = wr_acc && (ubc_index(paddr) == UBC_IDX_CTRL_C);
    assign wr_low   = wr_acc && (ubc_index(paddr) == UBC_IDX_DIV_LOW);  // [R3]
    assign wr_high  = wr_acc && (ubc_index(paddr) == UBC_IDX_DIV_HIGH); // [R3]
    assign reload   = wr_low || wr_high; // [R4]
    // a byte written in this cycle already counts for the reload
    assign divisor  = {ubc_merge(wr_high, pwdata[7:0], divisor_high_byte_q),
                       ubc_merge(wr_low, pwdata[7:0], divisor_low_byte_q)}; // [R2][R4]
    assign mspi     = ctrl_c_q[UBC_MODE_LSB +: 2] == UBC_MODE_MSPI;

    // zero wait states; a low enable stalls the bus
    assign pready  = ce;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // ==========================================================
    // control register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_c_q <= UBC_CTRL_C_RESET;
        end else if (wr_ctrl) begin
            ctrl_c_q <= pwdata[7:0];
        end
    end

    // ==========================================================
    // divisor byte pair
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            divisor_low_byte_q  <= UBC_DIV_RESET[7:0];
            divisor_high_byte_q <= UBC_DIV_RESET[15:8];
        end else begin
            if (wr_low) begin
                divisor_low_byte_q <= pwdata[7:0]; // [R2]
            end
            if (wr_high) begin
                divisor_high_byte_q <= pwdata[7:0]; // [R2]
            end
        end
    end

    // ==========================================================
    // read data captured in the setup phase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            pslverr_q <= !ubc_mapped(paddr);
            prdata_q  <= 32'h0000_0000;
            if (!pwrite && ubc_mapped(paddr)) begin
                unique case (ubc_index(paddr))
                    UBC_IDX_CTRL_C: begin
                        prdata_q[7:0] <= mspi ? (ctrl_c_q & UBC_MSPI_MASK) : ctrl_c_q;
                    end
                    UBC_IDX_DIV_LOW: begin
                        prdata_q[7:0] <= divisor_low_byte_q;
                    end
                    UBC_IDX_DIV_HIGH: begin
                        prdata_q[7:0] <= divisor_high_byte_q;
                    end
                    default: begin
                        // status word: count, clock level, running
                        prdata_q[15:0]             <= count;
                        prdata_q[UBC_STAT_CLK_BIT] <= xck_q;
                        prdata_q[UBC_STAT_RUN_BIT] <= (link_q == UBC_LINK_RUN);
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // prescaler
    ubc_prescaler u_presc (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .reload  (reload),
        .divisor (divisor),
        .tick    (tick),
        .count   (count)
    );

    assign baud_tick = tick;

    // ==========================================================
    // stop only at idle level; a stop tick with the clock low flips
    // nothing, so it must not count as a leading edge either
    logic link_stop;

    assign link_stop = (!spi_run || !mspi) && (!xck_q || tick);

    // ==========================================================
    // master spi transfer clock, idle low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            link_q <= UBC_LINK_IDLE;
            xck_q  <= 1'b0;
        end else if (ce) begin
            unique case (link_q)
                UBC_LINK_IDLE: begin
                    xck_q <= 1'b0;
                    // leave idle only in master spi mode
                    if (mspi && spi_run) begin
                        link_q <= UBC_LINK_RUN;
                    end
                end
                UBC_LINK_RUN: begin
                    if (tick) begin
                        xck_q <= !xck_q;
                    end
                    if (link_stop) begin
                        link_q <= UBC_LINK_IDLE;
                        xck_q  <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign transfer_clock_pin = xck_q;

    // ==========================================================
    // data sampling edge select
    logic lead_edge;
    logic trail_edge;
    logic sample_now;

    assign lead_edge  = (link_q == UBC_LINK_RUN) && tick && !xck_q && !link_stop;
    assign trail_edge = (link_q == UBC_LINK_RUN) && tick && xck_q;
    assign sample_now = ctrl_c_q[UBC_PHASE_BIT] ? trail_edge : lead_edge; // [R1]

    // the pulse comes out with its clock edge, both registered from the tick cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sample_pulse_q <= 1'b0;
            sample_bit_q   <= 1'b0;
        end else if (ce) begin
            sample_pulse_q <= sample_now; // [R1]
            if (sample_now) begin
                sample_bit_q <= spi_data_in; // [R1]
            end
        end
    end

    assign sample_pulse = sample_pulse_q;
    assign sample_bit   = sample_bit_q;

endmodule // ubc_top

// ### tb/ubc_chk_checker.sv
// assertions for the baud divisor / clock phase slice
// assumes it is bound onto ubc_top, one clock domain
module ubc_chk
    import ubc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        spi_run,
    input wire logic        spi_data_in,
    input wire logic        transfer_clock_pin,
    input wire logic        baud_tick,
    input wire logic        sample_pulse,
    input wire logic        sample_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  ctl_q, lo_q, hi_q;
    logic [15:0] cnt_q;
    logic        p1_q, p2_q;
    wire acc = psel & penable;
    wire map = paddr inside {12'h1c, 12'h20, 12'h24, 12'h28};
    wire wr = acc & pwrite & ce & pstrb[0];
    wire wdv = wr & (paddr == 12'h20 || paddr == 12'h24);
    wire [15:0] ndv = paddr[2] ? {pwdata[7:0], lo_q} : {hi_q, pwdata[7:0]};
    wire pin = transfer_clock_pin;
    wire sel_now = ctl_q[1] ? (!pin & p1_q) : (pin & !p1_q);
    wire sel_prv = ctl_q[1] ? (!p1_q & p2_q) : (p1_q & !p2_q);
    // ==========================================
    // register and prescaler model
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 8'h03;
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else if (wr) begin
            if (paddr == 12'h1c) ctl_q <= pwdata[7:0];
            if (paddr == 12'h20) lo_q <= pwdata[7:0];
            if (paddr == 12'h24) hi_q <= pwdata[7:0];
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) cnt_q <= 16'h0000;
        else if (wdv) cnt_q <= ndv;
        else if (ce) cnt_q <= (cnt_q == 16'h0000) ? {hi_q, lo_q} : cnt_q - 16'h0001;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            p1_q <= 1'b0;
            p2_q <= 1'b0;
        end else if (ce) begin
            p1_q <= pin;
            p2_q <= p1_q;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_catch;
        ##[0:1] sample_pulse;
    endsequence
    ready_a: assert property (pready == ce)
        else $error("pready differs from ce");
    bad_addr_a: assert property (acc && !map |-> pslverr)
        else $error("unmapped access without error");
    good_addr_a: assert property (acc && map |-> !pslverr)
        else $error("mapped access flagged");
    tick_a: assert property (ce |-> baud_tick == (cnt_q == 16'h0000 && !wdv))
        else $error("baud tick off the divisor count");
    edge_pulse_a: assert property (sel_now |-> s_catch)
        else $error("selected edge without sample");
    pulse_edge_a: assert property (sample_pulse |-> sel_now || sel_prv)
        else $error("sample away from selected edge");
    sample_bit_a: assert property (sample_pulse |-> sample_bit == spi_data_in)
        else $error("sampled bit wrong");
    clk_idle_a: assert property (!$past(spi_run) && !spi_run && !pin |=> !pin)
        else $error("transfer clock left idle");
endmodule // ubc_chk

bind ubc_top ubc_chk u_chk (.clk_sys, .arst_n, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .spi_run, .spi_data_in, .transfer_clock_pin,
    .baud_tick, .sample_pulse, .sample_bit);

// ### tb/ubc_peer.sv
// remote spi peer: shifts a pattern out on its launch edge
// assumes the transfer clock is seen on clk_sys
module ubc_peer (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic sclk,
    input  wire logic phase,
    output logic      sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pat_q;
    logic       clk_q;
    assign sdo = pat_q[7];
    // launch on the edge opposite the sampling one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pat_q <= 8'ha5;
            clk_q <= 1'b0;
        end else begin
            clk_q <= sclk;
            if (phase ? (sclk & !clk_q) : (!sclk & clk_q)) pat_q <= {pat_q[6:0], pat_q[7]};
        end
    end
endmodule // ubc_peer

// ### tb/test_usart_baud_and_clock_phase.sv
// self-checking bench for the baud divisor / clock phase slice
// assumes ubc_top, ubc_peer and the bound checker
module test_usart_baud_and_clock_phase;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, arst_n, ce, psel, penable, pwrite, spi_run, phase, pq, e;
    logic        pready, pslverr, spi_data_in, transfer_clock_pin, baud_tick;
    logic        sample_pulse, sample_bit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    int          err_total, n_tests, nr, np;

    ubc_top u_ubc_top (.clk_sys, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .spi_run, .spi_data_in, .transfer_clock_pin,
        .baud_tick, .sample_pulse, .sample_bit);
    ubc_peer u_ubc_peer (.clk_sys, .arst_n, .sclk(transfer_clock_pin), .phase,
        .sdo(spi_data_in));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        pq <= transfer_clock_pin;
        if (transfer_clock_pin === 1'b1 && pq === 1'b0) nr++;
        if (sample_pulse === 1'b1) np++;
    end
    // ==========================================
    // access and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task conclude;
        $display("tests=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_sys);
        err_total++;
        conclude;
    end
    // ==========================================
    // tests
    initial begin
        {arst_n, psel, penable, pwrite, spi_run, phase} = 6'h00;
        {ce, paddr, pwdata, pstrb} = {1'b1, 12'h000, 32'h0, 4'h0};
        nr = 0;
        np = 0;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(12'h1c, 32'h03, 1'b0);
        rd(12'h20, 32'h00, 1'b0);
        rd(12'h24, 32'h00, 1'b0);
        rd(12'h30, 32'h00, 1'b1);
        rd(12'h21, 32'h00, 1'b1);
        rd(12'h420, 32'h00, 1'b1);
        $display("test reset done");
        apb(1'b1, 12'h20, 8'h34, 4'h1);
        apb(1'b1, 12'h24, 8'h12, 4'h1);
        rd(12'h28, 32'h0000_1233, 1'b0);
        apb(1'b1, 12'h24, 8'h77, 4'h0);
        apb(1'b1, 12'h420, 8'h55, 4'h1);
        chk({31'h0, e}, 32'h1);
        rd(12'h20, 32'h34, 1'b0);
        rd(12'h24, 32'h12, 1'b0);
        $display("test divisor done");
        for (int p = 0; p < 2; p++) begin
            phase <= p[0];
            apb(1'b1, 12'h24, 8'h00, 4'h1);
            apb(1'b1, 12'h20, 8'h03, 4'h1);
            apb(1'b1, 12'h1c, p[0] ? 8'hc2 : 8'hc0, 4'h1);
            rd(12'h1c, p[0] ? 32'hc2 : 32'hc0, 1'b0);
            nr = 0;
            np = 0;
            spi_run <= 1'b1;
            repeat (20) @(posedge clk_sys);
            apb(1'b1, 12'h20, 8'h02, 4'h1);
            repeat (20) @(posedge clk_sys);
            spi_run <= 1'b0;
            repeat (20) @(posedge clk_sys);
            chk(np, nr);
            chk(nr > 4, 1);
            $display("test phase %0d done", p);
        end
        ce <= 1'b0;
        @(negedge clk_sys);
        chk(pready, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("test enable done");
        conclude;
    end
endmodule // test_usart_baud_and_clock_phase
